// ---- include/ccf_pkg.sv ----
package ccf_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned AXI_AW = 24;
    localparam logic [23:0] ADDR_RD_PTR = 24'h10_24e4;
    localparam logic [23:0] ADDR_WR_PTR = 24'h10_24e8;
    localparam logic [23:0] ADDR_DL_OFF = 24'h10_24ec;
    localparam logic [23:0] ADDR_TRACK = 24'h10_9000;
    localparam logic [23:0] ADDR_IRQ_STS = 24'h10_24f0;
    localparam logic [23:0] ADDR_IRQ_MSK = 24'h10_24f4;

    // ------------------------------------------------------------
    // field widths, positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned PTR_W = 12;
    localparam int unsigned DL_W = 14;
    localparam int unsigned TAG_W = 16;
    localparam int unsigned TRK_W = 16;
    localparam int unsigned TAG_LSB = 0;
    localparam int unsigned TRK_LSB = 16;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_ERR = 0;
    localparam int unsigned IRQ_DRAIN = 1;
    localparam int unsigned IRQ_TRACK = 2;
    localparam int unsigned IRQ_ALIGN = 3;

    localparam int unsigned FIFO_BYTES = 4096;
    localparam int unsigned CMD_BYTES = 4;
    localparam logic [11:0] PTR_STEP = 12'h004;
    localparam logic [11:0] PTR_ERR = 12'hfff;
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic [1:0] PTR_ALIGN_MASK = 2'h3;
    localparam logic [13:0] DL_RST = 14'h0000;
    localparam logic [13:0] DL_STEP = 14'h0004;
    localparam logic [15:0] TAG_RST = 16'h0000;
    localparam logic [15:0] TRK_RST = 16'h0000;
    localparam logic [15:0] TRK_FULL = 16'hffff;
    localparam logic [3:0] STS_RST = 4'h0;
    localparam logic [3:0] MSK_RST = 4'h0;
    localparam logic [4:0] DIV_STEPS = 5'h10;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [23:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [23:0] araddr;
        logic arvalid;
        logic rready;
    } ccf_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ccf_axi_rsp_t;

    typedef struct packed {
        logic cp_reset;
        logic fetch;
        logic error;
        logic dl_write;
        logic touch_valid;
        logic [15:0] touch_tag;
        logic [15:0] touch_pos;
        logic [15:0] track_lo;
        logic [15:0] track_span;
    } ccf_cp_in_t;

    typedef struct packed {
        logic [11:0] rd_ptr;
        logic [11:0] wr_ptr;
        logic [13:0] dl_off;
        logic empty;
        logic err;
        logic [11:0] level;
    } ccf_cp_out_t;

    typedef struct packed {
        logic busy;
        logic [4:0] cnt;
        logic [16:0] rem;
        logic [15:0] quo;
        logic [15:0] val;
        logic done;
    } ccf_div_st_t;

    typedef struct packed {
        ccf_cp_out_t cpo;
        ccf_axi_rsp_t rsp;
        logic aw_held;
        logic [23:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [15:0] tag;
        logic [3:0] sts;
        logic [3:0] msk;
        logic irq;
    } ccf_main_st_t;

endpackage

// ---- rtl/ccf_track_div.sv ----
`timescale 1ns/1ps
module ccf_track_div (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // request
    input wire logic start,
    input wire logic [15:0] pos,
    input wire logic [15:0] lo,
    input wire logic [15:0] span,
    // result
    output logic busy,
    output logic done,
    output logic [15:0] value
);
    import ccf_pkg::*;

    ccf_div_st_t s_r;
    ccf_div_st_t s_nxt;

    // ------------------------------------------------------------
    // shift-subtract divide: value = (pos - lo) * 2^16 / span
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] diff;
        logic [16:0] shl;
        diff = pos - lo;
        shl = '0;
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (!s_r.busy && start) begin
            // out-of-range touches clamp instead of dividing
            if (pos < lo) begin
                s_nxt.val = TRK_RST;
                s_nxt.done = 1'b1;
            end else if (span == 16'h0000 || diff >= span) begin
                s_nxt.val = TRK_FULL;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.busy = 1'b1;
                s_nxt.cnt = DIV_STEPS;
                s_nxt.rem = {1'b0, diff};
                s_nxt.quo = '0;
            end
        end else if (s_r.busy) begin
            shl = {s_r.rem[15:0], 1'b0};
            if (shl >= {1'b0, span}) begin
                s_nxt.rem = shl - {1'b0, span};
                s_nxt.quo = {s_r.quo[14:0], 1'b1};
            end else begin
                s_nxt.rem = shl;
                s_nxt.quo = {s_r.quo[14:0], 1'b0};
            end
            s_nxt.cnt = s_r.cnt - 5'h01;
            if (s_r.cnt == 5'h01) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.val = s_nxt.quo; // proportion of the range covered
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '{busy: 1'b0, cnt: 5'h00, rem: 17'h0_0000, quo: 16'h0000,
                     val: TRK_RST, done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign done = s_r.done;
    assign value = s_r.val;
endmodule

// ---- rtl/ccf_cmd_fifo_ptrs.sv ----
`timescale 1ns/1ps
module ccf_cmd_fifo_ptrs (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire ccf_pkg::ccf_axi_req_t axi_req,
    output ccf_pkg::ccf_axi_rsp_t axi_rsp,
    // coprocessor engine side
    input wire ccf_pkg::ccf_cp_in_t cp_in,
    output ccf_pkg::ccf_cp_out_t cp_out,
    // interrupt
    output logic irq
);
    import ccf_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // byte distance from read to write pointer, wrapping with the ring
    function automatic logic [11:0] ring_level(input logic [11:0] wr,
                                               input logic [11:0] rd);
        return wr - rd;
    endfunction

    function automatic logic addr_known(input logic [23:0] a);
        return (a == ADDR_RD_PTR) || (a == ADDR_WR_PTR) || (a == ADDR_DL_OFF) ||
               (a == ADDR_TRACK) || (a == ADDR_IRQ_STS) || (a == ADDR_IRQ_MSK);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ccf_main_st_t s_r;
    ccf_main_st_t s_nxt;

    logic div_start;
    logic div_busy;
    logic div_done;
    logic [15:0] div_val;

    // ------------------------------------------------------------
    // tracking value divider
    // ------------------------------------------------------------
    assign div_start = cp_in.touch_valid && !div_busy;

    ccf_track_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(div_start),
        .pos(cp_in.touch_pos),
        .lo(cp_in.track_lo),
        .span(cp_in.track_span),
        .busy(div_busy),
        .done(div_done),
        .value(div_val)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic do_wr;
        logic [31:0] old_v;
        logic [31:0] wv;
        logic [31:0] rv;
        logic [3:0] ev;
        logic [3:0] clr;
        logic host_rd_wr;
        logic host_wr_wr;
        logic host_dl_wr;
        do_wr = 1'b0;
        old_v = '0;
        wv = '0;
        rv = '0;
        ev = '0;
        clr = '0;
        host_rd_wr = 1'b0;
        host_wr_wr = 1'b0;
        host_dl_wr = 1'b0;
        s_nxt = s_r;

        // write address and data are taken independently
        if (axi_req.awvalid && s_r.rsp.awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_r.rsp.wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = axi_req.wdata;
            s_nxt.w_strb = axi_req.wstrb;
        end
        if (s_r.rsp.bvalid && axi_req.bready) begin
            s_nxt.rsp.bvalid = 1'b0;
        end

        // commit once both halves are held and no response is pending
        do_wr = s_r.aw_held && s_r.w_held && !s_r.rsp.bvalid;
        if (do_wr) begin
            unique case (s_r.aw_addr)
                ADDR_RD_PTR: old_v = {20'h0_0000, s_r.cpo.rd_ptr};
                ADDR_WR_PTR: old_v = {20'h0_0000, s_r.cpo.wr_ptr};
                ADDR_DL_OFF: old_v = {18'h0_0000, s_r.cpo.dl_off};
                ADDR_IRQ_MSK: old_v = {28'h000_0000, s_r.msk};
                default: old_v = '0;
            endcase
            wv = merge_strb(old_v, s_r.w_data, s_r.w_strb);
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.rsp.bvalid = 1'b1;
            s_nxt.rsp.bresp = addr_known(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_r.aw_addr)
                ADDR_RD_PTR: host_rd_wr = 1'b1;
                ADDR_WR_PTR: host_wr_wr = 1'b1;
                ADDR_DL_OFF: host_dl_wr = 1'b1;
                ADDR_IRQ_STS: clr = s_r.w_strb[0] ? wv[IRQ_W-1:0] : '0;
                ADDR_IRQ_MSK: s_nxt.msk = wv[IRQ_W-1:0];
                default: ;
            endcase
        end
        // a response in flight blocks the next address and data
        s_nxt.rsp.awready = !s_nxt.aw_held && !s_nxt.rsp.bvalid;
        s_nxt.rsp.wready = !s_nxt.w_held && !s_nxt.rsp.bvalid;

        // read channel: data from the cycle the address is taken
        if (axi_req.arvalid && s_r.rsp.arready) begin
            unique case (axi_req.araddr)
                ADDR_RD_PTR: rv = {20'h0_0000, s_r.cpo.rd_ptr};
                ADDR_WR_PTR: rv = {20'h0_0000, s_r.cpo.wr_ptr};
                ADDR_DL_OFF: rv = {18'h0_0000, s_r.cpo.dl_off};
                ADDR_TRACK: begin
                    rv[TAG_LSB +: TAG_W] = s_r.tag;
                    rv[TRK_LSB +: TRK_W] = div_val;
                end
                ADDR_IRQ_STS: rv = {28'h000_0000, s_r.sts};
                ADDR_IRQ_MSK: rv = {28'h000_0000, s_r.msk};
                default: rv = '0;
            endcase
            s_nxt.rsp.rvalid = 1'b1;
            s_nxt.rsp.rdata = rv;
            s_nxt.rsp.rresp = addr_known(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
            s_nxt.rsp.arready = 1'b0;
        end else if (s_r.rsp.rvalid && axi_req.rready) begin
            s_nxt.rsp.rvalid = 1'b0;
            s_nxt.rsp.arready = 1'b1;
        end

        // ------------------------------------------------------------
        // read pointer: fetch, host recovery write, error, reset
        // ------------------------------------------------------------
        // fetches are ignored on an empty ring or after an error
        if (cp_in.fetch && !s_r.cpo.empty && !s_r.cpo.err) begin
            s_nxt.cpo.rd_ptr = s_r.cpo.rd_ptr + PTR_STEP;
            if (s_nxt.cpo.rd_ptr == s_r.cpo.wr_ptr) begin
                ev[IRQ_DRAIN] = 1'b1;
            end
        end
        if (host_rd_wr) begin
            // only meant for error recovery; taken whenever it comes
            s_nxt.cpo.rd_ptr = wv[PTR_W-1:0];
        end
        if (cp_in.error) begin
            s_nxt.cpo.rd_ptr = PTR_ERR;
            ev[IRQ_ERR] = 1'b1;
        end

        // ------------------------------------------------------------
        // write pointer: host owned
        // ------------------------------------------------------------
        if (host_wr_wr) begin
            s_nxt.cpo.wr_ptr = wv[PTR_W-1:0];
            // stored as written; misalignment only flagged
            if ((wv[1:0] & PTR_ALIGN_MASK) != 2'h0) begin
                ev[IRQ_ALIGN] = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // display list output offset
        // ------------------------------------------------------------
        if (cp_in.dl_write) begin
            s_nxt.cpo.dl_off = s_r.cpo.dl_off + DL_STEP;
        end
        if (host_dl_wr) begin
            // host wins over a same-cycle advance
            s_nxt.cpo.dl_off = wv[DL_W-1:0];
        end

        // ------------------------------------------------------------
        // coprocessor reset clears the pointers
        // ------------------------------------------------------------
        if (cp_in.cp_reset) begin
            s_nxt.cpo.rd_ptr = PTR_RST;
            s_nxt.cpo.wr_ptr = PTR_RST;
            s_nxt.cpo.dl_off = DL_RST;
            ev[IRQ_ERR] = 1'b0;
            ev[IRQ_DRAIN] = 1'b0;
        end

        // ------------------------------------------------------------
        // tracker
        // ------------------------------------------------------------
        if (div_start) begin
            s_nxt.tag = cp_in.touch_tag;
        end
        ev[IRQ_TRACK] = div_done;

        // ------------------------------------------------------------
        // derived status for the coprocessor and the host
        // ------------------------------------------------------------
        s_nxt.cpo.err = (s_nxt.cpo.rd_ptr == PTR_ERR);
        s_nxt.cpo.empty = (s_nxt.cpo.rd_ptr == s_nxt.cpo.wr_ptr);
        s_nxt.cpo.level = s_nxt.cpo.err ? '0 :
                          ring_level(s_nxt.cpo.wr_ptr, s_nxt.cpo.rd_ptr);

        // sticky flags: a set in the clearing cycle survives
        s_nxt.sts = (s_r.sts & ~clr) | ev;
        s_nxt.irq = |(s_nxt.sts & s_nxt.msk);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r.cpo.rd_ptr <= PTR_RST;
            s_r.cpo.wr_ptr <= PTR_RST;
            s_r.cpo.dl_off <= DL_RST;
            s_r.cpo.empty <= 1'b1;
            s_r.cpo.err <= 1'b0;
            s_r.cpo.level <= '0;
            s_r.rsp.awready <= 1'b1;
            s_r.rsp.wready <= 1'b1;
            s_r.rsp.bvalid <= 1'b0;
            s_r.rsp.bresp <= RESP_OKAY;
            s_r.rsp.arready <= 1'b1;
            s_r.rsp.rvalid <= 1'b0;
            s_r.rsp.rdata <= '0;
            s_r.rsp.rresp <= RESP_OKAY;
            s_r.aw_held <= 1'b0;
            s_r.aw_addr <= '0;
            s_r.w_held <= 1'b0;
            s_r.w_data <= '0;
            s_r.w_strb <= '0;
            s_r.tag <= TAG_RST;
            s_r.sts <= STS_RST;
            s_r.msk <= MSK_RST;
            s_r.irq <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign axi_rsp = s_r.rsp;
    assign cp_out = s_r.cpo;
    assign irq = s_r.irq;
endmodule

// ---- verification/ccf_props.sv ----
`timescale 1ns/1ps
module ccf_props (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // watched ports
    input wire ccf_pkg::ccf_axi_req_t axi_req,
    input wire ccf_pkg::ccf_axi_rsp_t axi_rsp,
    input wire ccf_pkg::ccf_cp_in_t cp_in,
    input wire ccf_pkg::ccf_cp_out_t cp_out,
    input wire logic irq
);
    import ccf_pkg::*;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // no host commit can land at the next edge while both readies are up
    logic quiet;
    assign quiet = axi_rsp.awready && axi_rsp.wready && !cp_in.cp_reset;

    sequence wr_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence wr_answer;
        !axi_rsp.awready ##1 axi_rsp.bvalid;
    endsequence
    sequence rd_taken;
        axi_req.arvalid && axi_rsp.arready;
    endsequence

    chk_write_answer: assert property (wr_taken |=> wr_answer)
        else $error("write answer late or missing");
    chk_read_answer: assert property (rd_taken |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read answer late or missing");
    chk_fetch_step: assert property (cp_in.fetch && !cp_in.error && quiet && !cp_out.empty
        && !cp_out.err |=> cp_out.rd_ptr == $past(cp_out.rd_ptr) + PTR_STEP)
        else $error("read pointer did not step by one command");
    chk_fetch_refused: assert property (cp_in.fetch && cp_out.empty && !cp_in.error
        && quiet |=> $stable(cp_out.rd_ptr))
        else $error("fetch moved pointer of empty ring");
    chk_error_force: assert property (cp_in.error && !cp_in.cp_reset
        |=> cp_out.rd_ptr == PTR_ERR && cp_out.err)
        else $error("error did not force sentinel");
    chk_cp_reset: assert property (cp_in.cp_reset
        |=> cp_out.rd_ptr == PTR_RST && cp_out.dl_off == DL_RST)
        else $error("coprocessor reset did not clear pointers");
    chk_dl_step: assert property (cp_in.dl_write && quiet
        |=> cp_out.dl_off == $past(cp_out.dl_off) + DL_STEP)
        else $error("display list offset did not advance");
    chk_empty_flag: assert property (cp_out.empty == (cp_out.rd_ptr == cp_out.wr_ptr))
        else $error("empty flag disagrees with pointers");
    chk_level_calc: assert property (!cp_out.err |-> cp_out.level == cp_out.wr_ptr - cp_out.rd_ptr)
        else $error("fill level wrong");
endmodule

bind ccf_cmd_fifo_ptrs ccf_props ccf_props_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .cp_in(cp_in),
    .cp_out(cp_out),
    .irq(irq)
);

// ---- verification/ccf_host_model.sv ----
`timescale 1ns/1ps
module ccf_host_model (
    // clock
    input wire logic aclk,
    // register bus, master side
    output ccf_pkg::ccf_axi_req_t axi_req,
    input wire ccf_pkg::ccf_axi_rsp_t axi_rsp
);
    import ccf_pkg::*;

    initial begin
        axi_req = '0;
    end

    // released payload shows the inverse so a stale value never passes
    task automatic wr(input logic [23:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_left;
        logic w_left;
        aw_left = 1'b1;
        w_left = 1'b1;
        @(posedge aclk);
        axi_req.awaddr <= a;
        axi_req.awvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hf;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        while (aw_left || w_left) begin
            @(posedge aclk);
            if (aw_left && axi_rsp.awready) begin
                aw_left = 1'b0;
                axi_req.awvalid <= 1'b0;
                axi_req.awaddr <= ~a;
            end
            if (w_left && axi_rsp.wready) begin
                w_left = 1'b0;
                axi_req.wvalid <= 1'b0;
                axi_req.wdata <= ~d;
            end
        end
        do @(posedge aclk); while (!axi_rsp.bvalid);
        r = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask

    // pointer polling for fill and free space
    task automatic rd(input logic [23:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do @(posedge aclk); while (!axi_rsp.arready);
        axi_req.arvalid <= 1'b0;
        axi_req.araddr <= ~a;
        do @(posedge aclk); while (!axi_rsp.rvalid);
        d = axi_rsp.rdata;
        r = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask
endmodule

// ---- verification/ccf_cmd_fifo_ptrs_bench.sv ----
`timescale 1ns/1ps
module ccf_cmd_fifo_ptrs_bench;
    import ccf_pkg::*;

    // ----------------------------
    // signals
    // ----------------------------
    localparam logic [4:0] P_CPR = 5'h10;
    localparam logic [4:0] P_FETCH = 5'h08;
    localparam logic [4:0] P_ERR = 5'h04;
    localparam logic [4:0] P_DLW = 5'h02;
    localparam logic [4:0] P_TOUCH = 5'h01;
    logic aclk;
    logic aresetn;
    ccf_axi_req_t axi_req;
    ccf_axi_rsp_t axi_rsp;
    ccf_cp_in_t cp_in;
    ccf_cp_out_t cp_out;
    logic irq;
    int error_cnt = 0;
    int total_checks = 0;
    logic [31:0] rdat;
    logic [1:0] resp;
    logic [23:0] rst_addrs [6] = '{ADDR_RD_PTR, ADDR_WR_PTR, ADDR_DL_OFF, ADDR_TRACK,
                                   ADDR_IRQ_STS, ADDR_IRQ_MSK};

    ccf_cmd_fifo_ptrs ccf_cmd_fifo_ptrs_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .axi_req(axi_req),
        .axi_rsp(axi_rsp),
        .cp_in(cp_in),
        .cp_out(cp_out),
        .irq(irq)
    );

    ccf_host_model ccf_host_model_i (
        .aclk(aclk),
        .axi_req(axi_req),
        .axi_rsp(axi_rsp)
    );

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // ----------------------------
    // tasks
    // ----------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [23:0] a, input logic [31:0] exp);
        ccf_host_model_i.rd(a, rdat, resp);
        chk(rdat, exp);
    endtask

    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        ccf_host_model_i.wr(a, d, resp);
    endtask

    task automatic settle;
        @(posedge aclk);
        #1;
    endtask

    // strobes held for n edges, then dropped together
    task automatic pulse(input logic [4:0] m, input int n);
        @(posedge aclk);
        {cp_in.cp_reset, cp_in.fetch, cp_in.error, cp_in.dl_write, cp_in.touch_valid} <= m;
        repeat (n) @(posedge aclk);
        {cp_in.cp_reset, cp_in.fetch, cp_in.error, cp_in.dl_write, cp_in.touch_valid} <= 5'h00;
    endtask

    // range 0x0100 wide 0x0200; divider needs 17 cycles
    task automatic track(input logic [15:0] tag, input logic [15:0] pos, input logic [31:0] exp);
        @(posedge aclk);
        cp_in.touch_tag <= tag;
        cp_in.touch_pos <= pos;
        cp_in.track_lo <= 16'h0100;
        cp_in.track_span <= 16'h0200;
        pulse(P_TOUCH, 1);
        repeat (20) @(posedge aclk);
        rd_chk(ADDR_TRACK, exp);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        close_out;
    end

    // ----------------------------
    // tests
    // ----------------------------
    initial begin
        aresetn = 1'b0;
        cp_in = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rst_addrs[i]) rd_chk(rst_addrs[i], 32'h0000_0000);
        pulse(P_ERR, 1);
        settle;
        rd_chk(ADDR_RD_PTR, 32'h0000_0fff);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(ADDR_IRQ_MSK, 32'h0000_0001);
        settle;
        settle;
        chk({31'h0, irq}, 32'h0000_0001);
        wr(ADDR_IRQ_STS, 32'h0000_0001);
        settle;
        settle;
        chk({31'h0, irq}, 32'h0000_0000);
        wr(ADDR_RD_PTR, 32'h0000_0ff8);
        wr(ADDR_WR_PTR, 32'h0000_0004);
        settle;
        chk({20'h0, cp_out.level}, 32'h0000_000c);
        chk({31'h0, cp_out.empty}, 32'h0000_0000);
        pulse(P_FETCH, 3);
        settle;
        chk({20'h0, cp_out.rd_ptr}, 32'h0000_0004);
        chk({31'h0, cp_out.empty}, 32'h0000_0001);
        pulse(P_FETCH, 1);
        settle;
        rd_chk(ADDR_RD_PTR, 32'h0000_0004);
        rd_chk(ADDR_IRQ_STS, 32'h0000_0002);
        wr(ADDR_IRQ_STS, 32'h0000_0002);
        rd_chk(ADDR_IRQ_STS, 32'h0000_0000);
        wr(ADDR_DL_OFF, 32'h0000_2000);
        pulse(P_DLW, 3);
        rd_chk(ADDR_DL_OFF, 32'h0000_200c);
        pulse(P_CPR, 1);
        rd_chk(ADDR_RD_PTR, 32'h0000_0000);
        rd_chk(ADDR_DL_OFF, 32'h0000_0000);
        track(16'h1234, 16'h0200, 32'h8000_1234);
        track(16'h0007, 16'h0300, 32'hffff_0007);
        track(16'h0042, 16'h0050, 32'h0000_0042);
        wr(ADDR_TRACK, 32'hffff_ffff);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        rd_chk(ADDR_TRACK, 32'h0000_0042);
        ccf_host_model_i.rd(24'h10_2400, rdat, resp);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        chk(rdat, 32'h0000_0000);
        close_out;
    end
endmodule
